// ---- shared/limit_status_pkg.sv ----
// Constants, register map and types of the limit and status block
package limit_status_pkg;

    // Channel counts and widths
    localparam int NUM_CH = 5;
    localparam int NUM_TEMP = 3;
    localparam int NUM_FAN = 4;
    localparam int CH_W = 3;
    localparam int CNT_W = 22;

    // Analog channel indices, in conversion order
    localparam int CH_CPU = 0;
    localparam int CH_MAIN = 1;
    localparam int CH_R1 = 2;
    localparam int CH_LOCAL = 3;
    localparam int CH_R2 = 4;
    localparam int TEMP_CH [NUM_TEMP] = '{CH_R1, CH_LOCAL, CH_R2};

    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    typedef enum {seq_idle, seq_run} seq_state_t;

    // Register offsets
    localparam byte_t ADDR_CFG1 = 8'h40;
    localparam byte_t ADDR_STAT1 = 8'h41;
    localparam byte_t ADDR_STAT2 = 8'h42;
    localparam byte_t ADDR_MASK1 = 8'h74;
    localparam byte_t ADDR_MASK2 = 8'h75;
    localparam byte_t ADDR_CFG3 = 8'h78;
    localparam byte_t ADDR_TIMER_LIM = 8'h7A;
    localparam byte_t ADDR_LO [NUM_CH] = '{8'h46, 8'h48, 8'h4E, 8'h50, 8'h52};
    localparam byte_t ADDR_HI [NUM_CH] = '{8'h47, 8'h49, 8'h4F, 8'h51, 8'h53};
    localparam byte_t ADDR_VAL [NUM_CH] = '{8'h21, 8'h22, 8'h25, 8'h26, 8'h27};
    localparam byte_t ADDR_OT [NUM_TEMP] = '{8'h6A, 8'h6B, 8'h6C};
    localparam byte_t ADDR_FAN_LO [NUM_FAN] = '{8'h54, 8'h56, 8'h58, 8'h5A};
    localparam byte_t ADDR_FAN_HI [NUM_FAN] = '{8'h55, 8'h57, 8'h59, 8'h5B};

    // Reset values
    localparam byte_t LO_RST [NUM_CH] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
    localparam byte_t HI_RST = 8'hFF;
    localparam byte_t OT_RST = 8'hA4;
    localparam word_t FAN_LIM_RST = 16'hFFFF;
    localparam byte_t TIMER_LIM_RST = 8'h00;
    localparam byte_t CFG1_RST = 8'h01;
    localparam byte_t CFG3_RST = 8'h00;
    localparam byte_t MASK_RST = 8'h00;
    localparam byte_t VAL_RST = 8'h00;

    // Field positions
    localparam int START_BIT = 0;
    localparam int ALERT_EN_BIT = 0;
    localparam int SUMMARY_BIT = 7;
    localparam int CH_STAT_BIT [NUM_CH] = '{1, 2, 4, 5, 6};
    localparam int DIODE_STAT_BIT [2] = '{6, 7};
    localparam int FAN_STAT_BIT [NUM_FAN] = '{2, 3, 4, 5};
    localparam int OVT_BIT = 1;

    // Monitoring pass times and their cycle counts
    localparam int CLK_KHZ = 25000;
    localparam int PASS_AVG_MS = 146;
    localparam int PASS_FAST_MS = 19;
    localparam int PASS_AVG_CYC = PASS_AVG_MS * CLK_KHZ;
    localparam int PASS_FAST_CYC = PASS_FAST_MS * CLK_KHZ;

endpackage : limit_status_pkg

// ---- hw/limit_status_alert_logic.sv ----
// Limit comparison, sticky status, masking and alert output
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - High violation when value above high limit; low when value at or below low.
// - Voltage and temperature channels converted in a repeating round-robin order.
// - Start bit runs or stops monitoring; it is set after reset.
// - Each finished conversion is stored in that channel's value register.
// - One pass lasts 146 ms averaged, 19 ms with averaging off.
// - Fan periods are checked whenever they arrive, apart from the sequence.
// - Fan period and limit are 16 bits; period above limit means slow fan.
// - Window check on analog channels; fan check only in manual fan mode.
// - Status bit follows latest check: set when out of limits.
// - Status bits except overtemperature and summary are sticky until read after condition ends.
// - Overtemperature flag is live and drops as soon as the condition ends.
// - First status bit 7 reads one when any second status bit is set.
// - First status bits 6,5,4 temperatures; bits 2,1 main and CPU supply.
// - Second status bits 7 and 6 flag remote diode two and one faults.
// - Second status bit 5 flags fan four slow or timer limit exceeded.
// - Second status bits 4,3,2 flag fans three, two and one slow.
// - Second status bit 1 flags overtemperature limit exceeded.
// - Alert low while any unmasked source is out of limit, until read.
// - A mask bit blocks only the alert; the status bit still sets.
// - Alert can be routed to either of two pins.
// - Mask bits sit at the status bit positions; one blocks that source.
// - Alert output is off after reset until enable bit is set.
module limit_status_alert_logic
    import limit_status_pkg::*;
#(
    parameter int unsigned PASS_AVG_CYCLES = PASS_AVG_CYC,
    parameter int unsigned PASS_FAST_CYCLES = PASS_FAST_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic avg_disable,
    output logic adc_start,
    output logic [CH_W-1:0] adc_channel,
    output logic monitor_running,
    input wire logic adc_done,
    input wire logic [7:0] adc_result,
    input wire logic adc_diode_fault,
    input wire logic [NUM_FAN-1:0] fan_period_valid,
    input wire logic [15:0] fan_one_period,
    input wire logic [15:0] fan_two_period,
    input wire logic [15:0] fan_three_period,
    input wire logic [15:0] fan_four_period,
    input wire logic fan_manual_mode,
    input wire logic overtemp_pin_mode,
    input wire logic overtemp_timer_exceeded,
    output logic [7:0] overtemp_timer_limit,
    input wire logic alert_pin_select,
    output logic alert_a_out,
    output logic alert_a_oe,
    output logic alert_b_out,
    output logic alert_b_oe
);

    localparam logic [CNT_W-1:0] SLOT_AVG_LAST =
        CNT_W'(PASS_AVG_CYCLES / NUM_CH - 1);
    localparam logic [CNT_W-1:0] SLOT_FAST_LAST =
        CNT_W'(PASS_FAST_CYCLES / NUM_CH - 1);
    localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CH - 1);
    localparam logic [CH_W-1:0] CH_FIRST = CH_W'(0);

    byte_t lo_lim_reg [NUM_CH];
    byte_t hi_lim_reg [NUM_CH];
    byte_t val_reg [NUM_CH];
    byte_t ot_lim_reg [NUM_TEMP];
    word_t fan_lim_reg [NUM_FAN];
    word_t fan_period_vec [NUM_FAN];
    byte_t cfg1_reg, cfg3_reg, mask1_reg, mask2_reg, timer_lim_reg;
    byte_t stat1_reg, stat2_reg, stat1_set, stat2_set;
    byte_t status1_view, status2_view, rd_value;
    logic [NUM_CH-1:0] limit_cond_reg, limit_cond_next;
    logic [1:0] diode_cond_reg, diode_cond_next;
    logic [NUM_FAN-1:0] fan_cond_reg, fan_cond_next;
    logic [NUM_TEMP-1:0] ot_cond_reg, ot_cond_next;
    logic alert_active_reg, alert_next, rd1, rd2;
    seq_state_t state_reg;
    logic [CH_W-1:0] chan_reg;
    logic [CNT_W-1:0] cnt_reg, slot_last;

    // Window test: strictly above high, or at or below low
    function automatic logic out_of_window(input byte_t v, input byte_t lo,
                                           input byte_t hi);
        return (v > hi) || (v <= lo);
    endfunction : out_of_window

    // Next channel of the round robin
    function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0] c);
        return (c == CH_LAST) ? CH_FIRST : CH_W'(c + CH_W'(1));
    endfunction : next_chan

    assign fan_period_vec[0] = fan_one_period;
    assign fan_period_vec[1] = fan_two_period;
    assign fan_period_vec[2] = fan_three_period;
    assign fan_period_vec[3] = fan_four_period;
    assign overtemp_timer_limit = timer_lim_reg;
    assign rd1 = reg_rd && (reg_addr == ADDR_STAT1);
    assign rd2 = reg_rd && (reg_addr == ADDR_STAT2);

    // Writable configuration, mask and limit registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg1_reg <= CFG1_RST;
            cfg3_reg <= CFG3_RST;
            mask1_reg <= MASK_RST;
            mask2_reg <= MASK_RST;
            timer_lim_reg <= TIMER_LIM_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                lo_lim_reg[i] <= LO_RST[i];
                hi_lim_reg[i] <= HI_RST;
            end
            for (int t = 0; t < NUM_TEMP; t++) begin
                ot_lim_reg[t] <= OT_RST;
            end
            for (int f = 0; f < NUM_FAN; f++) begin
                fan_lim_reg[f] <= FAN_LIM_RST;
            end
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CFG1) cfg1_reg <= reg_wdata;
            if (reg_addr == ADDR_CFG3) cfg3_reg <= reg_wdata;
            if (reg_addr == ADDR_MASK1) mask1_reg <= reg_wdata;
            if (reg_addr == ADDR_MASK2) mask2_reg <= reg_wdata;
            if (reg_addr == ADDR_TIMER_LIM) timer_lim_reg <= reg_wdata;
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_addr == ADDR_LO[i]) lo_lim_reg[i] <= reg_wdata;
                if (reg_addr == ADDR_HI[i]) hi_lim_reg[i] <= reg_wdata;
            end
            for (int t = 0; t < NUM_TEMP; t++) begin
                if (reg_addr == ADDR_OT[t]) ot_lim_reg[t] <= reg_wdata;
            end
            // Fan limit is a 16-bit pair of bytes
            for (int f = 0; f < NUM_FAN; f++) begin
                if (reg_addr == ADDR_FAN_LO[f]) fan_lim_reg[f][7:0] <= reg_wdata;
                if (reg_addr == ADDR_FAN_HI[f]) fan_lim_reg[f][15:8] <= reg_wdata;
            end
        end
    end

    // Round-robin sequencer, one slot per analog channel
    assign slot_last = avg_disable ? SLOT_FAST_LAST : SLOT_AVG_LAST;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= seq_idle;
            chan_reg <= CH_FIRST;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                seq_idle: begin
                    cnt_reg <= '0;
                    chan_reg <= CH_FIRST;
                    if (cfg1_reg[START_BIT]) state_reg <= seq_run;
                end
                seq_run: begin
                    if (cnt_reg >= slot_last) begin
                        cnt_reg <= '0;
                        chan_reg <= next_chan(chan_reg);
                        if (!cfg1_reg[START_BIT]) state_reg <= seq_idle;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
            endcase
        end
    end
    assign adc_start = (state_reg == seq_run) && (cnt_reg == '0);
    assign adc_channel = chan_reg;
    assign monitor_running = (state_reg == seq_run);

    // Latest conversion result per channel
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CH; i++) val_reg[i] <= VAL_RST;
        end else if (adc_done) begin
            val_reg[chan_reg] <= adc_result;
        end
    end

    // Outcome of the most recent check of every source
    always_comb begin
        limit_cond_next = limit_cond_reg;
        diode_cond_next = diode_cond_reg;
        ot_cond_next = ot_cond_reg;
        fan_cond_next = fan_cond_reg;
        if (adc_done) begin
            limit_cond_next[chan_reg] = out_of_window(adc_result,
                lo_lim_reg[chan_reg], hi_lim_reg[chan_reg]);
            for (int t = 0; t < NUM_TEMP; t++) begin
                if (chan_reg == CH_W'(TEMP_CH[t])) begin
                    ot_cond_next[t] = adc_result > ot_lim_reg[t];
                end
            end
            if (chan_reg == CH_W'(CH_R1)) diode_cond_next[0] = adc_diode_fault;
            if (chan_reg == CH_W'(CH_R2)) diode_cond_next[1] = adc_diode_fault;
        end
        // Fan results arrive on their own schedule
        for (int f = 0; f < NUM_FAN; f++) begin
            if (fan_period_valid[f]) begin
                fan_cond_next[f] = fan_manual_mode &&
                    (fan_period_vec[f] > fan_lim_reg[f]);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            limit_cond_reg <= '0;
            diode_cond_reg <= '0;
            ot_cond_reg <= '0;
            fan_cond_reg <= '0;
        end else begin
            limit_cond_reg <= limit_cond_next;
            diode_cond_reg <= diode_cond_next;
            ot_cond_reg <= ot_cond_next;
            fan_cond_reg <= fan_cond_next;
        end
    end

    // Map present conditions onto status bit positions
    always_comb begin
        stat1_set = '0;
        stat2_set = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            stat1_set[CH_STAT_BIT[i]] = limit_cond_next[i];
        end
        stat2_set[DIODE_STAT_BIT[0]] = diode_cond_next[0];
        stat2_set[DIODE_STAT_BIT[1]] = diode_cond_next[1];
        for (int f = 0; f < NUM_FAN - 1; f++) begin
            stat2_set[FAN_STAT_BIT[f]] = fan_cond_next[f];
        end
        stat2_set[FAN_STAT_BIT[NUM_FAN-1]] = overtemp_pin_mode ?
            overtemp_timer_exceeded : fan_cond_next[NUM_FAN-1];
    end

    // Sticky status; a read clears only bits whose cause has gone
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stat1_reg <= '0;
            stat2_reg <= '0;
        end else begin
            stat1_reg <= stat1_set | (rd1 ? '0 : stat1_reg);
            stat2_reg <= stat2_set | (rd2 ? '0 : stat2_reg);
        end
    end

    // Visible status: live overtemperature bit and summary bit
    always_comb begin
        status2_view = stat2_reg;
        status2_view[OVT_BIT] = |ot_cond_reg;
        status1_view = stat1_reg;
        status1_view[SUMMARY_BIT] = |status2_view;
    end

    // Read data mux; unmapped offsets read zero
    always_comb begin
        rd_value = '0;
        if (reg_addr == ADDR_CFG1) rd_value = cfg1_reg;
        if (reg_addr == ADDR_CFG3) rd_value = cfg3_reg;
        if (reg_addr == ADDR_STAT1) rd_value = status1_view;
        if (reg_addr == ADDR_STAT2) rd_value = status2_view;
        if (reg_addr == ADDR_MASK1) rd_value = mask1_reg;
        if (reg_addr == ADDR_MASK2) rd_value = mask2_reg;
        if (reg_addr == ADDR_TIMER_LIM) rd_value = timer_lim_reg;
        for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == ADDR_LO[i]) rd_value = lo_lim_reg[i];
            if (reg_addr == ADDR_HI[i]) rd_value = hi_lim_reg[i];
            if (reg_addr == ADDR_VAL[i]) rd_value = val_reg[i];
        end
        for (int t = 0; t < NUM_TEMP; t++) begin
            if (reg_addr == ADDR_OT[t]) rd_value = ot_lim_reg[t];
        end
        for (int f = 0; f < NUM_FAN; f++) begin
            if (reg_addr == ADDR_FAN_LO[f]) rd_value = fan_lim_reg[f][7:0];
            if (reg_addr == ADDR_FAN_HI[f]) rd_value = fan_lim_reg[f][15:8];
        end
    end

    // Read data is captured before the clear takes effect
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_value;
        end
    end

    // Alert from unmasked status; summary bit is no source of its own
    assign alert_next = cfg3_reg[ALERT_EN_BIT] &&
        ((|(stat1_reg & ~mask1_reg)) ||
         (|(status2_view & ~mask2_reg)));
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            alert_active_reg <= 1'b0;
        end else begin
            alert_active_reg <= alert_next;
        end
    end

    // Open-drain alert, only the selected pin pulls low
    assign alert_a_out = 1'b0;
    assign alert_b_out = 1'b0;
    assign alert_a_oe = alert_active_reg && !alert_pin_select;
    assign alert_b_oe = alert_active_reg && alert_pin_select;

    AST_HIGH_LIMIT: assert property (@(posedge clk_sys) disable iff (reset)
        adc_done && (adc_result > hi_lim_reg[chan_reg])
        |=> limit_cond_reg[$past(chan_reg)] && stat1_reg != '0)
        else $error("high limit violation not flagged");

    AST_IN_WINDOW: assert property (@(posedge clk_sys) disable iff (reset)
        adc_done && (adc_result > lo_lim_reg[chan_reg])
        && (adc_result <= hi_lim_reg[chan_reg])
        |=> !limit_cond_reg[$past(chan_reg)])
        else $error("in-window value flagged");

    AST_LOW_LIMIT: assert property (@(posedge clk_sys) disable iff (reset)
        adc_done && (adc_result <= lo_lim_reg[chan_reg])
        |=> limit_cond_reg[$past(chan_reg)])
        else $error("low limit violation not flagged");

    AST_VALUE_STORE: assert property (@(posedge clk_sys) disable iff (reset)
        adc_done |=> val_reg[$past(chan_reg)] == $past(adc_result))
        else $error("conversion result not stored");

    AST_ROUND_ROBIN: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == seq_run) && (cnt_reg >= slot_last)
        |=> chan_reg == next_chan($past(chan_reg)) && cnt_reg == '0)
        else $error("channel sequence broken");

    AST_STOP: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == seq_run) && (cnt_reg >= slot_last)
        && !cfg1_reg[START_BIT] |=> !adc_start [*2])
        else $error("monitoring did not stop");

    AST_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
        !rd1 |=> (stat1_reg & $past(stat1_reg)) == $past(stat1_reg))
        else $error("sticky status bit lost");

    AST_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
        rd1 ##1 !rd1 && !adc_done |=> stat1_reg == $past(stat1_reg))
        else $error("status changed without cause after read");

    AST_SUMMARY: assert property (@(posedge clk_sys) disable iff (reset)
        rd1 |=> reg_rdata[SUMMARY_BIT] == $past(|status2_view))
        else $error("summary bit wrong");

    AST_OVT_LIVE: assert property (@(posedge clk_sys) disable iff (reset)
        adc_done && (chan_reg == CH_W'(CH_LOCAL)) && (ot_cond_reg == 3'h2)
        && (adc_result <= ot_lim_reg[1]) |=> !status2_view[OVT_BIT])
        else $error("overtemperature flag did not drop");

    AST_FAN_SLOW: assert property (@(posedge clk_sys) disable iff (reset)
        fan_period_valid[0] && fan_manual_mode
        && (fan_one_period > fan_lim_reg[0]) |=> stat2_reg[FAN_STAT_BIT[0]])
        else $error("slow fan not flagged");

    AST_MASKED: assert property (@(posedge clk_sys) disable iff (reset)
        ((stat1_reg & ~mask1_reg) == '0) && ((status2_view & ~mask2_reg) == '0)
        |=> !alert_a_oe && !alert_b_oe)
        else $error("masked source drove alert");

    AST_ALERT_ON: assert property (@(posedge clk_sys) disable iff (reset)
        cfg3_reg[ALERT_EN_BIT] && ((stat1_reg & ~mask1_reg) != '0)
        |=> alert_a_oe || alert_b_oe)
        else $error("alert not asserted");

    AST_ALERT_OFF: assert property (@(posedge clk_sys) disable iff (reset)
        !cfg3_reg[ALERT_EN_BIT] |=> !alert_active_reg)
        else $error("alert active while disabled");

endmodule : limit_status_alert_logic

`default_nettype wire

// ---- sim/adc_model.sv ----
// Converter model that answers each conversion start with one result
`timescale 1ns/100ps
`default_nettype none
module adc_model #(
    parameter int DLY = 3
) (
    input wire logic clk_sys,
    input wire logic adc_start,
    input wire logic [2:0] adc_channel,
    input wire logic [39:0] chan_vals,
    input wire logic [4:0] chan_faults,
    output logic adc_done,
    output logic [7:0] adc_result,
    output logic adc_diode_fault
);
    int cnt = 0;
    logic [2:0] ch = 3'h0;
    // Outputs start known
    initial begin
        adc_done = 1'b0;
        adc_result = 8'h00;
        adc_diode_fault = 1'b0;
    end
    // Count down from each start, then hand over one result
    always @(negedge clk_sys) begin
        adc_done <= 1'b0;
        if (adc_start) begin
            cnt <= DLY;
            ch <= adc_channel;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            adc_done <= 1'b1;
            adc_result <= chan_vals[ch*8 +: 8];
            adc_diode_fault <= chan_faults[ch];
        end else begin
            adc_result <= ~adc_result; // No stale result between answers
            adc_diode_fault <= ~adc_diode_fault;
        end
    end
endmodule : adc_model
`default_nettype wire

// ---- sim/limit_status_alert_logic_tb.sv ----
// Register level tests of the limit and status block
`timescale 1ns/100ps
`default_nettype none
module limit_status_alert_logic_tb;
    import limit_status_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    byte_t reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    byte_t reg_wdata = 8'h00;
    byte_t reg_rdata, adc_result, timer_lim;
    logic adc_start, adc_done, adc_diode_fault, monitor_running;
    logic [CH_W-1:0] adc_channel;
    logic [39:0] vals = {5{8'h50}};
    logic [4:0] faults = 5'h00;
    logic [NUM_FAN-1:0] fv = 4'h0;
    word_t fp = 16'h0000;
    logic manual = 1'b0;
    logic sel = 1'b0;
    logic a_oe, b_oe, a_out, b_out;
    logic avg_off = 1'b0;
    logic ot_mode = 1'b0;
    logic ot_exc = 1'b0;
    logic gap_on = 1'b0;
    logic avg_prev = 1'b0;
    int err_count = 0;
    int n_tests = 0;
    int exp_ch = 0;
    int gap = 0;
    // Shortened pass lengths and the slot each gives per channel
    localparam int AVG_CYC = 50;
    localparam int FAST_CYC = 25;
    localparam byte_t SLOT_A = 8'(AVG_CYC / NUM_CH);
    localparam byte_t SLOT_F = 8'(FAST_CYC / NUM_CH);

    always #20 clk_sys = ~clk_sys;

    limit_status_alert_logic #(.PASS_AVG_CYCLES(AVG_CYC),
        .PASS_FAST_CYCLES(FAST_CYC))
    limit_status_alert_logic_inst (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .avg_disable(avg_off),
        .adc_start(adc_start), .adc_channel(adc_channel),
        .monitor_running(monitor_running), .adc_done(adc_done),
        .adc_result(adc_result), .adc_diode_fault(adc_diode_fault),
        .fan_period_valid(fv), .fan_one_period(fp), .fan_two_period(fp),
        .fan_three_period(fp), .fan_four_period(fp),
        .fan_manual_mode(manual), .overtemp_pin_mode(ot_mode),
        .overtemp_timer_exceeded(ot_exc), .overtemp_timer_limit(timer_lim),
        .alert_pin_select(sel), .alert_a_out(a_out), .alert_a_oe(a_oe),
        .alert_b_out(b_out), .alert_b_oe(b_oe));

    adc_model adc_model_inst (.clk_sys(clk_sys), .adc_start(adc_start),
        .adc_channel(adc_channel), .chan_vals(vals), .chan_faults(faults),
        .adc_done(adc_done), .adc_result(adc_result),
        .adc_diode_fault(adc_diode_fault));

    task check(input string name, input byte_t seen, input byte_t exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task wr(input byte_t a, input byte_t v);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    task rc(input string n, input byte_t a, input byte_t e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        check(n, reg_rdata, e);
    endtask : rc

    task pass_wait;
        repeat (110) @(negedge clk_sys);
    endtask : pass_wait

    task fan(input word_t p);
        @(negedge clk_sys);
        fp = p;
        fv = 4'h1;
        @(negedge clk_sys);
        fv = 4'h0;
    endtask : fan

    task results;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // Channel and slot length of every conversion start
    always @(negedge clk_sys) begin
        gap <= gap + 1;
        if (adc_start === 1'b1) begin
            check("adc_channel", 8'(adc_channel), 8'(exp_ch));
            // Slots that straddle a change of averaging are skipped
            if (gap_on && avg_prev == avg_off)
                check("slot_len", 8'(gap), avg_off ? SLOT_F : SLOT_A);
            exp_ch <= (exp_ch + 1) % NUM_CH;
            gap <= 1;
            gap_on <= 1'b1;
            avg_prev <= avg_off;
        end
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (8000) @(posedge clk_sys);
        err_count++;
        results;
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        rc("cfg1", ADDR_CFG1, CFG1_RST);
        for (int i = 0; i < NUM_CH; i++) begin
            rc("low_lim", ADDR_LO[i], LO_RST[i]);
            rc("high_lim", ADDR_HI[i], HI_RST);
        end
        for (int i = 0; i < NUM_FAN; i++) begin
            rc("fan_lo", ADDR_FAN_LO[i], FAN_LIM_RST[7:0]);
            rc("fan_hi", ADDR_FAN_HI[i], FAN_LIM_RST[15:8]);
        end
        for (int i = 0; i < NUM_TEMP; i++)
            rc("ot_lim", ADDR_OT[i], OT_RST);
        rc("mask1", ADDR_MASK1, MASK_RST);
        rc("mask2", ADDR_MASK2, MASK_RST);
        rc("cfg3", ADDR_CFG3, CFG3_RST);
        rc("timer_lim", ADDR_TIMER_LIM, TIMER_LIM_RST);
        check("timer_port", timer_lim, TIMER_LIM_RST);
        rc("unmapped", 8'h10, 8'h00);
        // Values at the limits: equal high is fine, equal low is not
        wr(ADDR_HI[CH_CPU], 8'h80);
        wr(ADDR_LO[CH_MAIN], 8'h40);
        vals[7:0] = 8'h80;
        vals[15:8] = 8'h40;
        pass_wait;
        check("alert_off", 8'(a_oe), 8'h00);
        wr(ADDR_CFG3, 8'h01);
        repeat (3) @(negedge clk_sys);
        check("alert_on", 8'(a_oe), 8'h01);
        rc("val_cpu", ADDR_VAL[CH_CPU], 8'h80);
        rc("stat1", ADDR_STAT1, 8'h04);
        rc("stat1_held", ADDR_STAT1, 8'h04);
        vals[15:8] = 8'h50;
        pass_wait;
        check("alert_held", 8'(a_oe), 8'h01);
        rc("stat1_sticky", ADDR_STAT1, 8'h04);
        rc("stat1_clr", ADDR_STAT1, 8'h00);
        @(negedge clk_sys);
        check("alert_rel", 8'(a_oe), 8'h00);
        // Masked source still sets status
        wr(ADDR_MASK1, 8'h04);
        vals[15:8] = 8'h40;
        pass_wait;
        check("alert_mask", 8'(a_oe), 8'h00);
        rc("stat1_mask", ADDR_STAT1, 8'h04);
        vals[15:8] = 8'h50;
        pass_wait;
        rc("stat1_mclr", ADDR_STAT1, 8'h04);
        rc("stat1_mgone", ADDR_STAT1, 8'h00);
        wr(ADDR_MASK1, 8'h00);
        // One above the high limit, alert moved to the second pin
        vals[7:0] = 8'h81;
        sel = 1'b1;
        pass_wait;
        check("alert_b", 8'(b_oe), 8'h01);
        check("alert_a", 8'(a_oe), 8'h00);
        check("pin_level", 8'({a_out, b_out}), 8'h00);
        rc("stat1_hi", ADDR_STAT1, 8'h02);
        vals[7:0] = 8'h80;
        pass_wait;
        rc("stat1_hclr", ADDR_STAT1, 8'h02);
        rc("stat1_hgone", ADDR_STAT1, 8'h00);
        // Overtemperature flag is live
        vals[31:24] = 8'hA5;
        pass_wait;
        rc("stat2_ovt", ADDR_STAT2, 8'h02);
        rc("stat1_sum", ADDR_STAT1, 8'h80);
        vals[31:24] = 8'h50;
        pass_wait;
        rc("stat2_ovt_end", ADDR_STAT2, 8'h00);
        // Fan period equal to the limit passes, one above is slow
        manual = 1'b1;
        wr(ADDR_FAN_LO[0], 8'h00);
        wr(ADDR_FAN_HI[0], 8'h10);
        fan(16'h1000);
        rc("stat2_feq", ADDR_STAT2, 8'h00);
        fan(16'h1001);
        rc("stat2_fan", ADDR_STAT2, 8'h04);
        manual = 1'b0;
        fan(16'hFFFF);
        rc("stat2_fst", ADDR_STAT2, 8'h04);
        rc("stat2_fauto", ADDR_STAT2, 8'h00);
        // Timer limit flag takes the fan four position, and is sticky
        ot_mode = 1'b1;
        ot_exc = 1'b1;
        rc("stat2_timer", ADDR_STAT2, 8'h20);
        ot_exc = 1'b0;
        ot_mode = 1'b0;
        rc("stat2_tclr", ADDR_STAT2, 8'h20);
        // Sensor fault on the first remote channel, averaging off
        faults[CH_R1] = 1'b1;
        avg_off = 1'b1;
        pass_wait;
        rc("stat2_diode", ADDR_STAT2, 8'h40);
        faults = 5'h00;
        // Stopping the monitor
        wr(ADDR_CFG1, 8'h00);
        repeat (15) @(negedge clk_sys);
        check("running", 8'(monitor_running), 8'h00);
        rc("cfg1_off", ADDR_CFG1, 8'h00);
        results;
    end
endmodule : limit_status_alert_logic_tb
`default_nettype wire
